/* File: pin_mux_pkg.sv */
// Package with the constants and types of the pin function select and readback block
//
// Overview of operation
// RULE1 - Upper bit 4: C5 port or address 5
// RULE2 - Upper bit 0: C4 port or address 4
// RULE3 - Lower bit 12: C3 port or address 3
// RULE4 - Lower bits 8,4,0 select C2,C1,C0
// RULE5 - Reserved bits read zero; software writes zero
// RULE6 - Select bits reset 1 only ROM-off extension
// RULE7 - Software sets address function only in extension
// RULE8 - Pin-state bits show live port E levels
// RULE9 - Pin-state bits read-only, reset shows pin level
// RULE10 - Pin-state bits 11, 9, 5 read zero
// RULE11 - Pin levels pass two synchroniser flip-flops
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_C_UPPER   = 8'h00;
  localparam logic [7:0] OFS_C_LOWER   = 8'h04;
  localparam logic [7:0] OFS_E_STATE   = 8'h08;
  localparam logic [7:0] OFS_MODE_STAT = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_C5_SEL = 4;
  localparam int BIT_C4_SEL = 0;
  localparam int BIT_C3_SEL = 12;
  localparam int BIT_C2_SEL = 8;
  localparam int BIT_C1_SEL = 4;
  localparam int BIT_C0_SEL = 0;

  // Writable bits of each select register
  localparam logic [15:0] MASK_C_UPPER = 16'h0011;
  localparam logic [15:0] MASK_C_LOWER = 16'h1111;

  // Port E bits that have a pin (11, 9 and 5 have none)
  localparam logic [15:0] MASK_E_PINS  = 16'hF5DF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SEL_PORT = 16'h0000;
  localparam logic [5:0]  RST_SEL_NONE = 6'h00;
  localparam logic [5:0]  RST_SEL_ALL  = 6'h3F;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Widths and bus encodings
  // ----------------------------------------------------------------
  localparam int PORT_C_PINS = 6;
  localparam int PORT_E_PINS = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ----------------------------------------------------------------
  // Chip operating modes, as strapped
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXT_ROM_ON,
    MODE_EXT_ROM_OFF,
    MODE_ILLEGAL
  } op_mode_t;

  // Bus slave state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ_WAIT
  } bus_state_t;

endpackage

/* File: level_sync.sv */
// Multi-bit two-stage level synchroniser
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH  = 16,
  parameter int STAGES = 2
) (
  // Clock
  input  wire logic             clk,
  // Data
  input  wire logic [WIDTH-1:0] dataIn,
  output logic      [WIDTH-1:0] dataOut
);

  // ----------------------------------------------------------------
  // Flip-flop chain
  // ----------------------------------------------------------------
  // No reset on purpose: the synchronised value must follow the pins
  // even while the block is held in reset.
  logic [WIDTH-1:0] stage_r [STAGES];

  always_ff @(posedge clk) begin
    stage_r[0] <= dataIn;
    for (int i = 1; i < STAGES; i++) begin
      stage_r[i] <= stage_r[i-1];
    end
  end

  assign dataOut = stage_r[STAGES-1];

endmodule // level_sync

/* File: port_pin_function_select_readback.sv */
// Port C pin function select and port E pin-state readback with AHB-Lite slave
`timescale 1ns/1ns
module port_pin_function_select_readback (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,

  // Chip operating mode strap
  input  wire logic [1:0]  opMode,

  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,

  // General port C logic
  input  wire logic [5:0]  gpioCOut,
  input  wire logic [5:0]  gpioCOutEn,

  // External bus controller address lines 5..0
  input  wire logic [5:0]  busAddr,

  // Port C pins
  output logic      [5:0]  pinCOut,
  output logic      [5:0]  pinCOutEn,
  output logic      [5:0]  pinCAddrSel,

  // Port E pins
  input  wire logic [15:0] pinELevel
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pin_mux_pkg::bus_state_t busState_r;
  pin_mux_pkg::bus_state_t busState_nxt;
  pin_mux_pkg::op_mode_t   opMode_r;

  logic [5:0]  sel_r;
  logic [5:0]  sel_nxt;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;
  logic [5:0]  pinCOut_r;
  logic [5:0]  pinCOutEn_r;
  logic [15:0] eState_r;
  logic [15:0] eSync;
  logic [15:0] upperWord_c;
  logic [15:0] lowerWord_c;
  logic [5:0]  pinCAddrSel_r;

  wire        transValid;
  wire        takeWrite;
  wire        takeRead;
  wire        wrUpper;
  wire        wrLower;
  wire [15:0] wrData;
  wire [15:0] upperWord;
  wire [15:0] lowerWord;
  wire [15:0] modeWord;
  wire [31:0] readMux;
  wire        romOffExt;
  wire        singleChip;
  wire [5:0]  selReset;
  wire [5:0]  selEffective;
  wire        hitUpper;
  wire        hitLower;
  wire        hitEState;
  wire        hitMode;
  wire        pinC5AddrSelect;
  wire        pinC4AddrSelect;
  wire        pinC3AddrSelect;
  wire        pinC2AddrSelect;
  wire        pinC1AddrSelect;
  wire        pinC0AddrSelect;
  wire [31:0] rdUpper;
  wire [31:0] rdLower;
  wire [31:0] rdEState;
  wire [31:0] rdMode;

  // ----------------------------------------------------------------
  // Port E pin synchroniser
  // ----------------------------------------------------------------
  level_sync #(
    .WIDTH  (pin_mux_pkg::PORT_E_PINS),
    .STAGES (pin_mux_pkg::SYNC_STAGES)
  ) u_eSync (
    .clk     (ref_clk),
    .dataIn  (pinELevel),
    .dataOut (eSync)                                   // see RULE11
  );

  // The state register keeps sampling during reset, so its value after
  // reset is the pin level and not a constant.
  always_ff @(posedge ref_clk) begin
    eState_r <= eSync & pin_mux_pkg::MASK_E_PINS;      // see RULE8 see RULE9 see RULE10
  end

  // ----------------------------------------------------------------
  // Operating mode strap
  // ----------------------------------------------------------------
  // The strap is caught on every clock of reset and frozen after it,
  // so a strap that moves later cannot change the pin functions.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      opMode_r <= pin_mux_pkg::op_mode_t'(opMode);
    end
  end

  assign romOffExt  = (opMode == pin_mux_pkg::MODE_EXT_ROM_OFF);
  assign singleChip = (opMode_r == pin_mux_pkg::MODE_SINGLE_CHIP);
  assign selReset   = romOffExt ? pin_mux_pkg::RST_SEL_ALL
                                : pin_mux_pkg::RST_SEL_NONE; // see RULE6

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign transValid = hsel && hready &&
                      (htrans == pin_mux_pkg::HTRANS_NONSEQ ||
                       htrans == pin_mux_pkg::HTRANS_SEQ);
  assign takeWrite  = transValid && hwrite;
  assign takeRead   = transValid && !hwrite;

  // One decode of the held address serves both the write and read paths
  assign hitUpper  = (addr_r == pin_mux_pkg::OFS_C_UPPER);
  assign hitLower  = (addr_r == pin_mux_pkg::OFS_C_LOWER);
  assign hitEState = (addr_r == pin_mux_pkg::OFS_E_STATE);
  assign hitMode   = (addr_r == pin_mux_pkg::OFS_MODE_STAT);

  assign wrUpper = (busState_r == pin_mux_pkg::ST_WRITE) && hitUpper;
  assign wrLower = (busState_r == pin_mux_pkg::ST_WRITE) && hitLower;
  assign wrData  = hwdata[15:0];

  // ----------------------------------------------------------------
  // Select bit update
  // ----------------------------------------------------------------
  // Only the select bits are stored; reserved bits have no storage.
  always_comb begin
    sel_nxt = sel_r;
    if (wrUpper) begin
      sel_nxt[5] = wrData[pin_mux_pkg::BIT_C5_SEL];    // see RULE1
      sel_nxt[4] = wrData[pin_mux_pkg::BIT_C4_SEL];    // see RULE2
    end
    if (wrLower) begin
      sel_nxt[3] = wrData[pin_mux_pkg::BIT_C3_SEL];    // see RULE3
      sel_nxt[2] = wrData[pin_mux_pkg::BIT_C2_SEL];    // see RULE4
      sel_nxt[1] = wrData[pin_mux_pkg::BIT_C1_SEL];    // see RULE4
      sel_nxt[0] = wrData[pin_mux_pkg::BIT_C0_SEL];    // see RULE4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_r <= selReset;                               // see RULE6
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  // Stored bits shown as the stored value, not the effective one
  assign pinC5AddrSelect = sel_r[5];
  assign pinC4AddrSelect = sel_r[4];
  assign pinC3AddrSelect = sel_r[3];
  assign pinC2AddrSelect = sel_r[2];
  assign pinC1AddrSelect = sel_r[1];
  assign pinC0AddrSelect = sel_r[0];

  always_comb begin
    upperWord_c = pin_mux_pkg::RST_SEL_PORT;
    upperWord_c[pin_mux_pkg::BIT_C5_SEL] = pinC5AddrSelect;  // see RULE1
    upperWord_c[pin_mux_pkg::BIT_C4_SEL] = pinC4AddrSelect;  // see RULE2
  end

  always_comb begin
    lowerWord_c = pin_mux_pkg::RST_SEL_PORT;
    lowerWord_c[pin_mux_pkg::BIT_C3_SEL] = pinC3AddrSelect;  // see RULE3
    lowerWord_c[pin_mux_pkg::BIT_C2_SEL] = pinC2AddrSelect;  // see RULE4
    lowerWord_c[pin_mux_pkg::BIT_C1_SEL] = pinC1AddrSelect;  // see RULE4
    lowerWord_c[pin_mux_pkg::BIT_C0_SEL] = pinC0AddrSelect;  // see RULE4
  end

  assign upperWord = upperWord_c & pin_mux_pkg::MASK_C_UPPER; // see RULE5
  assign lowerWord = lowerWord_c & pin_mux_pkg::MASK_C_LOWER; // see RULE5
  assign modeWord  = {14'h0000, opMode_r};

  assign rdUpper  = {16'h0000, upperWord};
  assign rdLower  = {16'h0000, lowerWord};
  assign rdEState = {16'h0000, eState_r};
  assign rdMode   = {16'h0000, modeWord};

  // Unmapped offsets read as zero with an OKAY response.
  assign readMux = hitUpper  ? rdUpper  :
                   hitLower  ? rdLower  :
                   hitEState ? rdEState :
                   hitMode   ? rdMode   :
                               pin_mux_pkg::RST_RDATA;

  // ----------------------------------------------------------------
  // Bus slave state machine
  // ----------------------------------------------------------------
  // Writes finish with no wait state. Reads take one wait state so
  // that a read right after a write sees the written value.
  always_comb begin
    busState_nxt = busState_r;
    unique case (busState_r)
      pin_mux_pkg::ST_IDLE,
      pin_mux_pkg::ST_WRITE: begin
        if (takeWrite) begin
          busState_nxt = pin_mux_pkg::ST_WRITE;
        end else if (takeRead) begin
          busState_nxt = pin_mux_pkg::ST_READ_WAIT;
        end else begin
          busState_nxt = pin_mux_pkg::ST_IDLE;
        end
      end
      pin_mux_pkg::ST_READ_WAIT: begin
        busState_nxt = pin_mux_pkg::ST_IDLE;
      end
      default: begin
        busState_nxt = pin_mux_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busState_r <= pin_mux_pkg::ST_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_r <= 8'h00;
    end else if (transValid) begin
      addr_r <= {haddr[7:2], 2'h0};
    end
  end

  // Pin-state and mode writes hit no storage and are dropped.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hreadyout_r <= 1'h1;
    end else begin
      hreadyout_r <= !(busState_nxt == pin_mux_pkg::ST_READ_WAIT);
    end
  end

  // Read data is held until the next read so a slow master still sees it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hrdata_r <= pin_mux_pkg::RST_RDATA;
    end else if (busState_r == pin_mux_pkg::ST_READ_WAIT) begin
      hrdata_r <= readMux;                             // see RULE9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hresp_r <= pin_mux_pkg::HRESP_OKAY;
    end else begin
      hresp_r <= pin_mux_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Port C pin multiplexer
  // ----------------------------------------------------------------
  // Software must not pick the address function in single-chip mode;
  // should it do so, the pin stays with the port so no stray address
  // is driven. The stored bit still reads back as written.
  assign selEffective = singleChip ? pin_mux_pkg::RST_SEL_NONE : sel_r; // see RULE7

  genvar g;
  for (g = 0; g < pin_mux_pkg::PORT_C_PINS; g++) begin : g_pinC
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        pinCOut_r[g]   <= 1'h0;
        pinCOutEn_r[g] <= 1'h0;
      end else if (selEffective[g]) begin
        pinCOut_r[g]   <= busAddr[g];                  // see RULE1 see RULE2 see RULE3 see RULE4
        pinCOutEn_r[g] <= 1'h1;
      end else begin
        pinCOut_r[g]   <= gpioCOut[g];
        pinCOutEn_r[g] <= gpioCOutEn[g];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinCAddrSel_r <= pin_mux_pkg::RST_SEL_NONE;
    end else begin
      pinCAddrSel_r <= selEffective;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = hresp_r;
  assign pinCOut     = pinCOut_r;
  assign pinCOutEn   = pinCOutEn_r;
  assign pinCAddrSel = pinCAddrSel_r;

  // Size is ignored: every access is treated as a whole word.
  wire unusedBits = ^{haddr[31:8], haddr[1:0], hsize, hwdata[31:16]};

endmodule // port_pin_function_select_readback

/* File: pin_mux_asserts.sv */
// Port checks for the pin function select and readback block
`timescale 1ns/1ns
module pin_mux_asserts (
  // Clock, reset, strap
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [1:0]  opMode,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins
  input wire logic [5:0]  gpioCOut,
  input wire logic [5:0]  gpioCOutEn,
  input wire logic [5:0]  busAddr,
  input wire logic [5:0]  pinCOut,
  input wire logic [5:0]  pinCOutEn,
  input wire logic [5:0]  pinCAddrSel,
  input wire logic [15:0] pinELevel
);
  localparam logic [7:0] A_UP = pin_mux_pkg::OFS_C_UPPER;
  localparam logic [7:0] A_LO = pin_mux_pkg::OFS_C_LOWER;
  localparam logic [7:0] A_E  = pin_mux_pkg::OFS_E_STATE;

  logic        taken;
  logic        wrPend_r;
  logic [7:0]  reqAddr_r;
  logic [3:0]  eStill_r;
  logic [15:0] rdMask;

  assign taken  = hsel && hready && htrans[1];
  assign rdMask = (reqAddr_r == A_UP) ? pin_mux_pkg::MASK_C_UPPER :
                  (reqAddr_r == A_LO) ? pin_mux_pkg::MASK_C_LOWER :
                  (reqAddr_r == A_E)  ? pin_mux_pkg::MASK_E_PINS : 16'h0003;

  // Age of the port E pattern, so reads are only judged once it has settled
  always_ff @(posedge ref_clk) begin
    if (taken) reqAddr_r <= haddr[7:0];
    wrPend_r <= taken && hwrite && !sys_rst;
    if (sys_rst || pinELevel != $past(pinELevel)) eStill_r <= 4'h0;
    else if (eStill_r != 4'hF) eStill_r <= eStill_r + 4'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_PIN_OUT: assert property (
    !$past(sys_rst) |-> pinCOut == (($past(busAddr) & pinCAddrSel) | ($past(gpioCOut) & ~pinCAddrSel)))
    else $error("port C level from wrong source");
  AST_PIN_EN: assert property (
    !$past(sys_rst) |-> pinCOutEn == (pinCAddrSel | ($past(gpioCOutEn) & ~pinCAddrSel)))
    else $error("port C enable from wrong source");
  AST_RST_SEL: assert property (
    $fell(sys_rst) |=> pinCAddrSel == {6{$past(opMode, 2) == pin_mux_pkg::MODE_EXT_ROM_OFF}})
    else $error("select bits left reset wrong");
  AST_SINGLE: assert property (
    opMode == pin_mux_pkg::MODE_SINGLE_CHIP |-> pinCAddrSel == 6'h00)
    else $error("address function in single-chip mode");
  AST_SEL_LO: assert property (
    wrPend_r && reqAddr_r == A_LO && opMode != 2'h0 |-> ##2 pinCAddrSel[3:0] ==
      {$past(hwdata[12], 2), $past(hwdata[8], 2), $past(hwdata[4], 2), $past(hwdata[0], 2)})
    else $error("lower select write misplaced");
  AST_SEL_UP: assert property (
    wrPend_r && reqAddr_r == A_UP && opMode != 2'h0 |-> ##2 pinCAddrSel[5:4] ==
      {$past(hwdata[4], 2), $past(hwdata[0], 2)})
    else $error("upper select write misplaced");
  AST_RESERVED: assert property (
    $rose(hreadyout) |-> (hrdata & ~{16'h0000, rdMask}) == 32'h0000_0000)
    else $error("reserved read bit set");
  AST_E_LEVEL: assert property (
    $rose(hreadyout) && reqAddr_r == A_E && $past(eStill_r, 2) >= 4'h5
      |-> hrdata[15:0] == ($past(pinELevel, 3) & pin_mux_pkg::MASK_E_PINS))
    else $error("port E state not the settled pin level");
  AST_OKAY: assert property (
    hresp == pin_mux_pkg::HRESP_OKAY)
    else $error("bus response not OKAY");

  CV_ROM_OFF: cover property ($fell(sys_rst) && opMode == 2'h2);
  CV_E_READ: cover property ($rose(hreadyout) && reqAddr_r == A_E);
  CV_LO_WRITE: cover property (wrPend_r && reqAddr_r == A_LO);
endmodule // pin_mux_asserts

bind port_pin_function_select_readback pin_mux_asserts chk (
  .ref_clk, .sys_rst, .opMode, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .gpioCOut, .gpioCOutEn, .busAddr, .pinCOut, .pinCOutEn, .pinCAddrSel, .pinELevel
);

/* File: ext_pins.sv */
// Far side model: bus controller address lines and port E pins
`timescale 1ns/1ns
module ext_pins (
  // Clock
  input  wire logic        ref_clk,
  // Pin levels set by the bench
  input  wire logic [15:0] eSet,
  // Toward the block
  output logic      [5:0]  busAddr,
  output logic      [15:0] pinELevel
);
  // Address steps every cycle so a stale mux path shows at once
  initial busAddr = 6'h00;
  always @(posedge ref_clk) busAddr <= busAddr + 6'h01;
  // Pins move off the edge, as a truly asynchronous level would
  assign #13 pinELevel = eSet;
endmodule // ext_pins

/* File: port_pin_function_select_readback_tb.sv */
// Testbench for the pin function select and readback block
`timescale 1ns/1ns
module port_pin_function_select_readback_tb;
  localparam logic [7:0] A_UP   = pin_mux_pkg::OFS_C_UPPER;
  localparam logic [7:0] A_LO   = pin_mux_pkg::OFS_C_LOWER;
  localparam logic [7:0] A_E    = pin_mux_pkg::OFS_E_STATE;
  localparam logic [7:0] A_NONE = 8'h10;

  logic        ref_clk;
  logic        sys_rst;
  logic [1:0]  opMode;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [5:0]  gpioCOut;
  logic [5:0]  gpioCOutEn;
  logic [5:0]  busAddr;
  logic [5:0]  pinCOut;
  logic [5:0]  pinCOutEn;
  logic [5:0]  pinCAddrSel;
  logic [15:0] pinELevel;
  logic [15:0] eSet;
  logic [31:0] rd;
  logic [15:0] pat [3] = '{16'hFFFF, 16'hA5A5, 16'h5A5A};
  int          miscompares;
  int          checked;

  port_pin_function_select_readback uut (.ref_clk, .sys_rst, .opMode, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .gpioCOut, .gpioCOutEn,
    .busAddr, .pinCOut, .pinCOutEn, .pinCAddrSel, .pinELevel);
  ext_pins env (.ref_clk, .eSet, .busAddr, .pinELevel);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----
  // Bus and check tasks
  // ----
  task automatic end_sim();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the slave; a hang ends the run as a failure
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= pin_mux_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic do_reset(input logic [1:0] m);
    sys_rst <= 1'b1;
    opMode  <= m;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    miscompares = 0;
    checked = 0;
    sys_rst = 1'b1;
    opMode = 2'h0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    gpioCOut = 6'h2A;
    gpioCOutEn = 6'h15;
    eSet = 16'hFFFF;
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      rdchk(A_UP, (m == 2) ? 32'h11 : 32'h0);
      rdchk(A_LO, (m == 2) ? 32'h1111 : 32'h0);
      check({26'h0, pinCAddrSel}, (m == 2) ? 32'h3F : 32'h0);
      rdchk(A_E, {16'h0, eSet & ~16'h0A20});
      rdchk(pin_mux_pkg::OFS_MODE_STAT, {30'h0, m[1:0]});
      // Address function is asked for only in the two extension modes
      if (m == 1 || m == 2) begin
        wr_all(32'hFFFF_FFFF);
        rdchk(A_UP, 32'h11);
        rdchk(A_LO, 32'h1111);
        check({26'h0, pinCOutEn}, 32'h3F);
        wr_all(32'h0);
        rdchk(A_NONE, 32'h0);
      end
      check({26'h0, pinCOut}, {26'h0, gpioCOut});
      check({26'h0, pinCOutEn}, {26'h0, gpioCOutEn});
    end
    do_reset(2'h1);
    for (int i = 0; i < 6; i++) begin
      bus((i < 4) ? A_LO : A_UP, 1'b1, 32'h1 << (4 * (i % 4)));
      rdchk(A_NONE, 32'h0);
      check({26'h0, pinCAddrSel}, 32'h1 << i);
      bus((i < 4) ? A_LO : A_UP, 1'b1, 32'h0);
    end
    foreach (pat[k]) begin
      eSet <= pat[k];
      repeat (8) @(posedge ref_clk);
      bus(A_E, 1'b1, ~{16'h0, pat[k]});
      rdchk(A_E, {16'h0, pat[k] & ~16'h0A20});
    end
    // A pin change this close to the read must not reach it yet
    // A single-stage path would already show the new level at this read
    eSet <= 16'h0000;
    @(posedge ref_clk);
    rdchk(A_E, {16'h0, pat[2] & ~16'h0A20});
    repeat (4) @(posedge ref_clk);
    rdchk(A_E, 32'h0);
    end_sim();
  end

  task automatic wr_all(input logic [31:0] d);
    bus(A_UP, 1'b1, d);
    bus(A_LO, 1'b1, d);
  endtask
endmodule // port_pin_function_select_readback_tb
